// ### design/fdc_cfg_pkg.sv
package fdc_cfg_pkg;
  localparam logic [7:0] FLOPPY_EN_OFS = 8'h4F;
  localparam logic [7:0] ROUTE_A_OFS = 8'h60;
  localparam logic [7:0] ROUTE_B_OFS = 8'h61;
  localparam logic [7:0] STATUS_LO_OFS = 8'h6A;
  localparam logic [7:0] STATUS_HI_OFS = 8'h6B;
  localparam logic [7:0] FLOPPY_EN_RESET = 8'h21;
  localparam logic [7:0] ROUTE_RESET = 8'h80;
  localparam logic [7:0] FLOPPY_EN_WMASK = 8'hFB;
  localparam logic [7:0] ROUTE_WMASK = 8'h8F;
  localparam int FPU_ERR_BIT = 7;
  localparam int MOUSE_BIT = 6;
  localparam int DOE_BIT = 5;
  localparam int RTC_ALE_BIT = 4;
  localparam int DOCK_BIT = 3;
  localparam int SEC_FLOPPY_BIT = 1;
  localparam int PRI_FLOPPY_BIT = 0;
  localparam int ROUTE_DIS_BIT = 7;
  localparam int FPU_IRQ_NUM = 13;
  localparam logic [15:0] PRI_FLOPPY_BASE = 16'h03F0;
  localparam logic [15:0] SEC_FLOPPY_BASE = 16'h0370;
  localparam logic [3:0] FLOPPY_HOLE = 4'h6;
  localparam logic [3:0] FLOPPY_LAST = 4'h7;
  localparam logic [15:0] ROUTE_LEGAL = 16'hDEF8;
  // synchroniser reset value: the three active-low pins start at their idle high level
  localparam logic [20:0] PIN_SYNC_RESET = 21'h000007;
endpackage : fdc_cfg_pkg

// ### design/cfg_if.sv
`timescale 1ns/10ps
interface cfg_if;
  logic [7:0] floppy_en;
  logic [7:0] route_a;
  logic [7:0] route_b;
  logic [1:0] pci_int_act;
  logic [15:0] xbus_irq;
  logic fpu_irq;
  logic [15:0] irq_mix;
  logic [15:0] io_addr;
  logic io_cycle;
  logic claim;
  modport regs (output floppy_en, route_a, route_b, pci_int_act, xbus_irq, fpu_irq,
                output io_addr, io_cycle, input irq_mix, claim);
  modport router (input route_a, route_b, pci_int_act, xbus_irq, fpu_irq, output irq_mix);
  modport decode (input floppy_en, io_addr, io_cycle, output claim);
endinterface : cfg_if

// ### design/floppy_io_decode.sv
`timescale 1ns/10ps
module floppy_io_decode
  import fdc_cfg_pkg::*;
(
  cfg_if.decode bus
);
  // one floppy window: eight ports with the one at offset 6 left to other devices
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] base);
    hit = (addr[15:3] == base[15:3]) && (addr[2:0] != FLOPPY_HOLE[2:0]);
  endfunction : hit

  always_comb begin
    bus.claim = bus.io_cycle &&
      ((bus.floppy_en[PRI_FLOPPY_BIT] && hit(bus.io_addr, PRI_FLOPPY_BASE)) ||
       (bus.floppy_en[SEC_FLOPPY_BIT] && hit(bus.io_addr, SEC_FLOPPY_BASE)));
  end
endmodule : floppy_io_decode

// ### design/pci_irq_router.sv
`timescale 1ns/10ps
module pci_irq_router
  import fdc_cfg_pkg::*;
(
  cfg_if.router bus
);
  // one-hot target of a route register; reserved codes and disabled routes give none
  function automatic logic [15:0] target(input logic [7:0] route);
    logic [15:0] one;
    one = 16'h0001 << route[3:0];
    target = (route[ROUTE_DIS_BIT] || !ROUTE_LEGAL[route[3:0]]) ? 16'h0000 : one;
  endfunction : target

  logic [15:0] tgt_a;
  logic [15:0] tgt_b;
  logic [15:0] fpu_vec;

  always_comb begin
    tgt_a = target(bus.route_a);
    tgt_b = target(bus.route_b);
    fpu_vec = 16'h0000;
    fpu_vec[FPU_IRQ_NUM] = bus.fpu_irq;
    // routed inputs drop the expansion-bus source; shared targets are ored
    bus.irq_mix = ((bus.xbus_irq | fpu_vec) & ~(tgt_a | tgt_b)) |
                  (tgt_a & {16{bus.pci_int_act[0]}}) |
                  (tgt_b & {16{bus.pci_int_act[1]}});
  end
endmodule : pci_irq_router

// ### design/floppy_irq_cfg.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module floppy_irq_cfg
  import fdc_cfg_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // pci i/o decode, same clock
  input wire logic [15:0] io_addr_i,
  input wire logic io_cycle_i,
  output logic floppy_claim_o,
  // pins from outside
  input wire logic fpu_error_in_n_i,
  input wire logic [1:0] pci_int_line_n_i,
  input wire logic [15:0] xbus_irq_i,
  input wire logic xbus_clock_strap_i,
  input wire logic dock_req_event_pin_i,
  // internal sources, same clock
  input wire logic ignore_numeric_req_i,
  input wire logic disk_output_enable_n_i,
  input wire logic rtc_addr_latch_en_i,
  input wire logic sysmgmt_out_five_i,
  input wire logic sysmgmt_out_four_i,
  input wire logic board_dma_ack_two_n_i,
  input wire logic dock_dma_ack_n_i,
  // outputs
  output logic ignore_numeric_error_out_n_o,
  output logic [15:0] irq_o,
  output logic mouse_irq_select_o,
  output logic doe_sysmgmt_out_five_pin_o,
  output logic rtc_addr_latch_en_sysmgmt_out_four_pin_o,
  output logic dack_pin_n_o,
  output logic board_dma_req_two_o,
  output logic external_event_n_o
);
  cfg_if bus ();

  logic [7:0] floppy_en;
  logic [7:0] route_a;
  logic [7:0] route_b;
  logic next_strap;
  logic strap;
  logic strap_done;
  logic next_strap_done;
  logic [7:0] next_floppy_en;
  logic [7:0] next_route_a;
  logic [7:0] next_route_b;
  logic [7:0] next_rdata;

  // two-flop synchronisers for all pin inputs
  logic [20:0] sync1;
  logic [20:0] sync2;
  logic [20:0] pin_raw;
  assign pin_raw = {dock_req_event_pin_i, xbus_clock_strap_i, xbus_irq_i,
                    pci_int_line_n_i, fpu_error_in_n_i};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= PIN_SYNC_RESET;
      sync2 <= PIN_SYNC_RESET;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  logic fpu_err_act;
  logic [1:0] pci_act;
  logic [15:0] xbus_irq_s;
  logic strap_s;
  logic dock_pin_s;
  assign fpu_err_act = ~sync2[0];
  assign pci_act = ~sync2[2:1];
  assign xbus_irq_s = sync2[18:3];
  assign strap_s = sync2[19];
  assign dock_pin_s = sync2[20];

  // register file
  always_comb begin
    next_floppy_en = floppy_en;
    next_route_a = route_a;
    next_route_b = route_b;
    if (wr_i) begin
      unique case (addr_i)
        FLOPPY_EN_OFS: next_floppy_en = wdata_i & FLOPPY_EN_WMASK;
        ROUTE_A_OFS: next_route_a = wdata_i & ROUTE_WMASK;
        ROUTE_B_OFS: next_route_b = wdata_i & ROUTE_WMASK;
        default: ; // status and unmapped writes are dropped
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      floppy_en <= FLOPPY_EN_RESET;
      route_a <= ROUTE_RESET;
      route_b <= ROUTE_RESET;
    end else begin
      floppy_en <= next_floppy_en;
      route_a <= next_route_a;
      route_b <= next_route_b;
    end
  end

  // the strap is caught once, after the synchroniser has settled past reset
  logic [1:0] settle;
  logic [1:0] next_settle;
  always_comb begin
    next_settle = settle;
    next_strap = strap;
    next_strap_done = strap_done;
    if (settle != 2'h3) begin
      next_settle = settle + 2'h1;
    end else if (!strap_done) begin
      next_strap = strap_s;
      next_strap_done = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      settle <= 2'h0;
      strap <= 1'b0;
      strap_done <= 1'b0;
    end else begin
      settle <= next_settle;
      strap <= next_strap;
      strap_done <= next_strap_done;
    end
  end

  // read data stands the cycle after the strobe only
  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        FLOPPY_EN_OFS: next_rdata = floppy_en;
        ROUTE_A_OFS: next_rdata = route_a;
        ROUTE_B_OFS: next_rdata = route_b;
        STATUS_LO_OFS: next_rdata = {7'h00, strap};
        STATUS_HI_OFS: next_rdata = 8'h00;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // submodules
  assign bus.floppy_en = floppy_en;
  assign bus.route_a = route_a;
  assign bus.route_b = route_b;
  assign bus.pci_int_act = pci_act;
  assign bus.xbus_irq = xbus_irq_s;
  assign bus.fpu_irq = floppy_en[FPU_ERR_BIT] & fpu_err_act;
  assign bus.io_addr = io_addr_i;
  assign bus.io_cycle = io_cycle_i;

  floppy_io_decode u_decode (
    .bus(bus.decode)
  );

  pci_irq_router u_router (
    .bus(bus.router)
  );

  // pin function selects and registered outputs
  logic next_ignore_numeric_error_out_n_n;
  logic next_doe;
  logic next_ale;
  logic next_dack_n;
  logic next_drq;
  logic next_event_n;
  always_comb begin
    // ignore-numeric-error only asserts while the fpu error is present
    next_ignore_numeric_error_out_n_n = ~(floppy_en[FPU_ERR_BIT] & fpu_err_act & ignore_numeric_req_i);
    next_doe = floppy_en[DOE_BIT] ? disk_output_enable_n_i : sysmgmt_out_five_i;
    next_ale = floppy_en[RTC_ALE_BIT] ? rtc_addr_latch_en_i : sysmgmt_out_four_i;
    next_dack_n = floppy_en[DOCK_BIT] ? dock_dma_ack_n_i : board_dma_ack_two_n_i;
    next_drq = floppy_en[DOCK_BIT] ? 1'b0 : dock_pin_s;
    next_event_n = floppy_en[DOCK_BIT] ? dock_pin_s : 1'b1;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      floppy_claim_o <= 1'b0;
      irq_o <= 16'h0000;
      ignore_numeric_error_out_n_o <= 1'b1;
      mouse_irq_select_o <= 1'b0;
      doe_sysmgmt_out_five_pin_o <= 1'b0;
      rtc_addr_latch_en_sysmgmt_out_four_pin_o <= 1'b0;
      dack_pin_n_o <= 1'b1;
      board_dma_req_two_o <= 1'b0;
      external_event_n_o <= 1'b1;
    end else begin
      rdata_o <= next_rdata;
      floppy_claim_o <= bus.claim;
      irq_o <= bus.irq_mix;
      ignore_numeric_error_out_n_o <= next_ignore_numeric_error_out_n_n;
      mouse_irq_select_o <= floppy_en[MOUSE_BIT];
      doe_sysmgmt_out_five_pin_o <= next_doe;
      rtc_addr_latch_en_sysmgmt_out_four_pin_o <= next_ale;
      dack_pin_n_o <= next_dack_n;
      board_dma_req_two_o <= next_drq;
      external_event_n_o <= next_event_n;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_FPU_IRQ: assert property (
    (floppy_en[FPU_ERR_BIT] && fpu_err_act) |=> irq_o[FPU_IRQ_NUM])
    else $error("fpu error did not raise irq 13");
  AST_IGNORE_NUMERIC_ERROR_OUT_N_GATE: assert property (
    !fpu_err_act |=> ignore_numeric_error_out_n_o)
    else $error("ignore-numeric-error asserted without fpu error");
  AST_MOUSE_SEL: assert property (
    (wr_i && addr_i == FLOPPY_EN_OFS) |=> ##1 mouse_irq_select_o == $past(wdata_i[MOUSE_BIT], 2))
    else $error("mouse select does not follow register bit");
  AST_DOE_MUX: assert property (
    !floppy_en[DOE_BIT] |=> doe_sysmgmt_out_five_pin_o == $past(sysmgmt_out_five_i))
    else $error("output five pin not driven from control level");
  AST_ALE_MUX: assert property (
    floppy_en[RTC_ALE_BIT] |=> rtc_addr_latch_en_sysmgmt_out_four_pin_o == $past(rtc_addr_latch_en_i))
    else $error("output four pin not carrying the rtc latch enable");
  AST_DOCK_MUX: assert property (
    floppy_en[DOCK_BIT] |=> !board_dma_req_two_o && dack_pin_n_o == $past(dock_dma_ack_n_i))
    else $error("docking pin functions not selected");
  AST_PRI_CLAIM: assert property (
    (io_cycle_i && io_addr_i == PRI_FLOPPY_BASE) |=> floppy_claim_o == $past(floppy_en[0]))
    else $error("primary floppy claim wrong");
  AST_SEC_HOLE: assert property (
    (io_cycle_i && io_addr_i == (SEC_FLOPPY_BASE | 16'h0006)) |=> !floppy_claim_o)
    else $error("secondary floppy hole claimed");
  AST_ROUTE_MASK: assert property (
    (!route_a[ROUTE_DIS_BIT] && route_a[3:0] == 4'hA && !pci_act[0] &&
     route_b[ROUTE_DIS_BIT]) |=> !irq_o[10])
    else $error("routed input not masked from expansion bus");
  AST_ROUTE_RESV: assert property (
    (rd_i && (addr_i == ROUTE_A_OFS || addr_i == ROUTE_B_OFS)) |=> rdata_o[6:4] == 3'h0)
    else $error("route reserved bits read nonzero");
  AST_STATUS_RO: assert property (
    (wr_i && addr_i == STATUS_LO_OFS) |=> $stable(floppy_en) && $stable(route_a))
    else $error("status write changed a register");
  AST_STATUS_ZERO: assert property (
    (rd_i && addr_i == STATUS_LO_OFS) |=> rdata_o[2:1] == 2'h0 && rdata_o[0] == strap)
    else $error("status read wrong");
endmodule : floppy_irq_cfg

// ### verification/reg_master.sv
`timescale 1ns/10ps
module reg_master (
  // clock
  input wire logic mclk_i,
  // register port
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // the slave never stalls, so each strobe lasts exactly one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge mclk_i);
    d = rdata_i;
  endtask : rd
endmodule : reg_master

// ### verification/floppy_irq_cfg_bench.sv
`timescale 1ns/10ps
`define CHK(a, e) chk(a, e)
module floppy_irq_cfg_bench;
  import fdc_cfg_pkg::*;
  logic mclk_i = 1'b0, rst_i = 1'b1, io_cyc = 1'b0, fpu_n = 1'b1, strap = 1'b1;
  logic pin = 1'b1, claim, ignore_numeric_error_out_n_n, mouse, doe, ale, dack_n, drq, ev_n, wr, rd;
  logic [1:0] pin_n = 2'b00;
  logic smo5 = 1'b1, smo4 = 1'b0;
  logic [15:0] io_addr = 16'h0000, xirq = 16'h0000, irq;
  logic [7:0] addr, wdata, rdata, d, v;
  logic [7:0] ta[4] = '{8'h4F, 8'h60, 8'h61, 8'h6A};
  logic [7:0] tw[4] = '{8'hFF, 8'hFF, 8'hF0, 8'hFF};
  logic [7:0] te[4] = '{8'hFB, 8'h8F, 8'h80, 8'h01};
  int fail_count = 0, compares = 0, cycles = 0;
  bit ok;

  reg_master reg_master_i (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata));
  floppy_irq_cfg floppy_irq_cfg_i (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .io_addr_i(io_addr),
    .io_cycle_i(io_cyc), .floppy_claim_o(claim), .fpu_error_in_n_i(fpu_n),
    .pci_int_line_n_i(pin_n), .xbus_irq_i(xirq), .xbus_clock_strap_i(strap),
    .dock_req_event_pin_i(pin), .ignore_numeric_req_i(1'b1),
    .disk_output_enable_n_i(1'b0), .rtc_addr_latch_en_i(1'b1), .sysmgmt_out_five_i(smo5),
    .sysmgmt_out_four_i(smo4), .board_dma_ack_two_n_i(1'b0), .dock_dma_ack_n_i(1'b1),
    .ignore_numeric_error_out_n_o(ignore_numeric_error_out_n_n), .irq_o(irq), .mouse_irq_select_o(mouse),
    .doe_sysmgmt_out_five_pin_o(doe), .rtc_addr_latch_en_sysmgmt_out_four_pin_o(ale), .dack_pin_n_o(dack_n),
    .board_dma_req_two_o(drq), .external_event_n_o(ev_n));

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // async pins pass two sync flops plus the output flop; five cycles is margin
  task automatic settle();
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : settle
  task automatic do_reset();
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    settle();
  endtask : do_reset

  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    settle();
    `CHK(irq, 16'h0000);
    `CHK({ignore_numeric_error_out_n_n, dack_n}, 2'b10);
    reg_master_i.rd(8'h4F, d);
    `CHK(d, FLOPPY_EN_RESET);
    reg_master_i.rd(8'h6B, d);
    `CHK(d, 8'h00);
    reg_master_i.rd(8'h62, d);
    `CHK(d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      reg_master_i.rd(ta[i], d);
      reg_master_i.wr(ta[i], tw[i]);
      reg_master_i.rd(ta[i], d);
      `CHK(d, te[i]);
    end
    // routed inputs are taken to be level mode in the controller
    for (int c = 0; c < 16; c++) begin
      ok = c inside {[3:7], [9:12], 14, 15};
      reg_master_i.wr(8'h60, 8'(c));
      @(posedge mclk_i);
      pin_n <= 2'b10;
      xirq <= 16'h0000;
      settle();
      `CHK(irq, ok ? 16'h0001 << c : 16'h0000);
      @(posedge mclk_i);
      pin_n <= 2'b11;
      xirq <= 16'hFFFF;
      settle();
      `CHK(irq, ok ? ~(16'h0001 << c) : 16'hFFFF);
    end
    reg_master_i.wr(8'h61, 8'h0A);
    reg_master_i.wr(8'h60, 8'h0A);
    @(posedge mclk_i);
    pin_n <= 2'b01;
    xirq <= 16'h0000;
    settle();
    `CHK(irq, 16'h0400);
    @(posedge mclk_i);
    pin_n <= 2'b10;
    settle();
    `CHK(irq, 16'h0400);
    reg_master_i.wr(8'h60, 8'h85);
    @(posedge mclk_i);
    pin_n <= 2'b00;
    settle();
    `CHK(irq, 16'h0400);
    for (int k = 0; k < 2; k++) begin
      reg_master_i.wr(8'h4F, k ? 8'h80 : 8'h00);
      @(posedge mclk_i);
      fpu_n <= 1'b0;
      settle();
      `CHK(irq[13], k[0]);
      `CHK(ignore_numeric_error_out_n_n, !k[0]);
    end
    @(posedge mclk_i);
    fpu_n <= 1'b1;
    // the system-management levels flip after the second pass so the system-management leg of each mux sees both levels
    for (int k = 0; k < 4; k++) begin
      v = k[0] ? 8'h78 : 8'h00;
      reg_master_i.wr(8'h4F, v);
      @(posedge mclk_i);
      pin <= !v[3];
      smo5 <= !k[1];
      smo4 <= k[1];
      settle();
      `CHK(mouse, v[6]);
      `CHK(doe, v[5] ? 1'b0 : smo5);
      `CHK(ale, v[4] ? 1'b1 : smo4);
      `CHK({dack_n, drq, ev_n}, {v[3], !v[3], !v[3]});
    end
    for (int e = 0; e < 4; e++) begin
      reg_master_i.wr(8'h4F, 8'(e));
      for (int b = 0; b < 2; b++) begin
        for (int o = 0; o < 9; o++) begin
          @(posedge mclk_i);
          io_addr <= (b ? 16'h0370 : 16'h03F0) + 16'(o);
          io_cyc <= 1'b1;
          repeat (2) @(posedge mclk_i);
          @(negedge mclk_i);
          `CHK(claim, e[b] && o != 6 && o < 8);
        end
      end
    end
    @(posedge mclk_i);
    io_cyc <= 1'b0;
    strap <= 1'b0;
    do_reset();
    reg_master_i.rd(8'h4F, d);
    `CHK(d, FLOPPY_EN_RESET);
    reg_master_i.rd(8'h6A, d);
    `CHK(d, 8'h00);
    print_verdict();
  end
endmodule : floppy_irq_cfg_bench
